// ---- inc/nvt_pkg.sv ----
// Shared constants, types and decode helpers for the trim register bank
package nvt_pkg;

  // ==========================================================================
  // Register map
  localparam int         NUM_REGS          = 5;
  localparam logic [7:0] ADDR_REF_SCALE    = 8'h00;
  localparam logic [7:0] ADDR_TEMP_SLOPE   = 8'h01;
  localparam logic [7:0] ADDR_GAIN_SPARE   = 8'h02;
  localparam logic [7:0] ADDR_SPARE_A      = 8'h03;
  localparam logic [7:0] ADDR_SPARE_B      = 8'h04;
  localparam logic [7:0] ADDR_LAST         = ADDR_SPARE_B;

  // ==========================================================================
  // Field layout and values
  localparam int         GAIN_SEL_POS      = 0;
  localparam int         GAIN_SEL_W        = 2;
  localparam int         SPARE_POS         = 2;
  localparam logic [7:0] NV_BLANK          = 8'h00;
  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [7:0] OUT_OF_RANGE_DATA = 8'hFF;
  localparam logic [3:0] BIT_ACK           = 4'h8;
  // Arbitrary device-type prefix, override per product
  localparam logic [3:0] DEVICE_TYPE_DEF   = 4'hA;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int T_WRITE_MS      = 20;
  localparam int NV_WRITE_CYCLES = (T_WRITE_MS * CLK_HZ) / 1000;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {ST_IDLE, ST_ID, ST_ADDR, ST_WDATA, ST_RDATA} nvt_state_t;

  typedef struct packed {
    logic [7:0]        ref_code;
    logic [7:0]        slope_code;
    logic signed [8:0] slope_factor;
    logic [2:0]        output_gain_factor;
  } nvt_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } nvt_wr_t;

  // ==========================================================================
  // Decode helpers
  function automatic logic [2:0] gain_decode(input logic [GAIN_SEL_W-1:0] sel);
    case (sel)
      2'h0:    gain_decode = 3'h1;
      2'h3:    gain_decode = 3'h4;
      default: gain_decode = 3'h2;
    endcase
  endfunction

  // Midscale-centred: code 0 gives -255, full scale gives +255 (units of 1/255)
  function automatic logic signed [8:0] slope_decode(input logic [7:0] code);
    slope_decode = $signed({code, 1'b0} - 9'h0FF);
  endfunction

endpackage

// ---- verilog/nvt_nv_store.sv ----
// Nonvolatile byte array with self-timed write cycle
`timescale 1ns/100ps
`default_nettype none

module nvt_nv_store #(
  parameter int WRITE_CYCLES = nvt_pkg::NV_WRITE_CYCLES,
  parameter int NUM          = nvt_pkg::NUM_REGS
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             wr_valid,
  input  wire nvt_pkg::nvt_wr_t wr,
  output logic                  busy,
  output logic [8*NUM-1:0]      words
);
  import nvt_pkg::*;

  localparam int TW = $clog2(WRITE_CYCLES + 1);

  // ==========================================================================
  // Storage cells
  // No reset on the array: contents must survive reset like the real cells
  // Blank cells at power-up; a declaration value keeps the array single-driven
  logic [7:0]    mem [NUM] = '{default: NV_BLANK};
  logic [TW-1:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (clk_en && wr_valid) begin
      mem[wr.addr[2:0]] <= wr.data;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      words[8*i +: 8] = mem[i];
    end
  end

  // ==========================================================================
  // Write cycle timer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (wr_valid) begin
        cnt_reg <= TW'(WRITE_CYCLES);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign busy = (cnt_reg != '0);

endmodule

`default_nettype wire

// ---- verilog/nvt_trim_bank.sv ----
// Trim register bank with two-wire serial slave front end
`timescale 1ns/100ps
`default_nettype none

module nvt_trim_bank #(
  parameter int         WRITE_CYCLES = nvt_pkg::NV_WRITE_CYCLES,
  parameter logic [3:0] DEVICE_TYPE  = nvt_pkg::DEVICE_TYPE_DEF
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  input  wire logic              addr_strap_2,
  input  wire logic              addr_strap_1,
  input  wire logic              addr_strap_0,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  output var nvt_pkg::nvt_cfg_t  cfg,
  output logic                   nv_busy
);
  import nvt_pkg::*;

  // ==========================================================================
  // Pin synchronisers and edge detection
  logic [1:0]      scl_sync_reg;
  logic [1:0]      sda_sync_reg;
  logic [2:0]      strap_s1_reg;
  logic [2:0]      strap_s2_reg;
  logic            scl_d_reg;
  logic            sda_d_reg;
  logic            scl;
  logic            sda;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      strap_s1_reg <= 3'h0;
      strap_s2_reg <= 3'h0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else if (clk_en) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      strap_s1_reg <= {addr_strap_2, addr_strap_1, addr_strap_0};
      strap_s2_reg <= strap_s1_reg;
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  assign scl = scl_sync_reg[1];
  assign sda = sda_sync_reg[1];

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = clk_en && scl && !scl_d_reg;
  assign scl_fall  = clk_en && !scl && scl_d_reg;
  assign start_det = clk_en && scl && scl_d_reg && sda_d_reg && !sda;
  assign stop_det  = clk_en && scl && scl_d_reg && !sda_d_reg && sda;

  // ==========================================================================
  // Slave state
  nvt_state_t      st_reg;
  logic [3:0]      bit_cnt_reg;
  logic [7:0]      shift_reg;
  logic [7:0]      ptr_reg;
  logic [7:0]      tx_reg;
  logic [7:0]      wbuf_reg;
  logic            wfull_reg;
  logic            sda_low_reg;
  logic            recall_reg;
  logic [7:0]      regs_reg [NUM_REGS];
  logic [8*NUM_REGS-1:0] nv_words;
  logic [8*NUM_REGS-1:0] regs_flat;
  logic            id_match;
  logic            bus_hold;
  logic            ack_rise;
  logic            commit;
  logic            nv_wr_valid;
  nvt_wr_t         nv_wr;

  assign id_match    = (shift_reg[7:1] == {DEVICE_TYPE, strap_s2_reg});
  // Recall and write cycle both lock the slave out of the bus
  assign bus_hold    = nv_busy || recall_reg;
  assign ack_rise    = scl_rise && (bit_cnt_reg == BIT_ACK) && !bus_hold;
  // The SCL rise that precedes STOP counts as one bit; a real bit also needs a fall
  assign commit      = stop_det && (st_reg == ST_WDATA) && wfull_reg
                       && (bit_cnt_reg <= 4'h1);
  assign nv_wr_valid = commit && (ptr_reg <= ADDR_LAST);

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    read_reg = (a <= ADDR_LAST) ? regs_reg[a[2:0]] : OUT_OF_RANGE_DATA;
  endfunction

  // ==========================================================================
  // Byte framing and protocol sequence
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg      <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
    end else if (clk_en) begin
      if (bus_hold || stop_det) begin
        st_reg      <= ST_IDLE;
        bit_cnt_reg <= 4'h0;
      end else if (start_det) begin
        st_reg      <= ST_ID;
        bit_cnt_reg <= 4'h0;
      end else if (scl_rise && st_reg != ST_IDLE) begin
        if (bit_cnt_reg != BIT_ACK) begin
          shift_reg   <= {shift_reg[6:0], sda};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else begin
          bit_cnt_reg <= 4'h0;
          case (st_reg)
            ST_ID: begin
              if (!id_match) begin
                st_reg <= ST_IDLE;
              end else if (shift_reg[0]) begin
                st_reg <= ST_RDATA;
              end else begin
                st_reg <= ST_ADDR;
              end
            end
            ST_ADDR:  st_reg <= ST_WDATA;
            ST_WDATA: st_reg <= ST_WDATA;
            ST_RDATA: begin
              // Master NACK ends the read
              if (sda) begin
                st_reg <= ST_IDLE;
              end
            end
            default:  st_reg <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // Register pointer and read data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_reg <= 8'h00;
      tx_reg  <= 8'h00;
    end else if (ack_rise && !stop_det && !start_det) begin
      case (st_reg)
        ST_ID: begin
          if (id_match && shift_reg[0]) begin
            tx_reg <= read_reg(ptr_reg);
          end
        end
        ST_ADDR:  ptr_reg <= shift_reg;
        ST_RDATA: begin
          ptr_reg <= ptr_reg + 8'h01;
          tx_reg  <= read_reg(ptr_reg + 8'h01);
        end
        default:  ptr_reg <= ptr_reg;
      endcase
    end
  end

  // ==========================================================================
  // Write data holding
  // Data sits here until STOP; a later byte replaces it at the same address
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wbuf_reg  <= 8'h00;
      wfull_reg <= 1'b0;
    end else if (clk_en) begin
      if (start_det || stop_det || bus_hold) begin
        wfull_reg <= 1'b0;
      end else if (ack_rise && st_reg == ST_WDATA) begin
        wbuf_reg  <= shift_reg;
        wfull_reg <= 1'b1;
      end else if (scl_fall && st_reg == ST_WDATA && bit_cnt_reg != 4'h0) begin
        // A further data byte has started: STOP now comes mid-byte
        wfull_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // SDA drive: ack and read bits change only while SCL is low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_low_reg <= 1'b0;
    end else if (clk_en) begin
      if (bus_hold || stop_det || start_det) begin
        sda_low_reg <= 1'b0;
      end else if (scl_fall) begin
        case (st_reg)
          ST_ID:    sda_low_reg <= (bit_cnt_reg == BIT_ACK) && id_match;
          ST_ADDR:  sda_low_reg <= (bit_cnt_reg == BIT_ACK);
          ST_WDATA: sda_low_reg <= (bit_cnt_reg == BIT_ACK);
          ST_RDATA: sda_low_reg <= (bit_cnt_reg != BIT_ACK) && !tx_reg[~bit_cnt_reg[2:0]];
          default:  sda_low_reg <= 1'b0;
        endcase
      end
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = !sda_low_reg;

  // ==========================================================================
  // Working registers, recalled from nonvolatile cells after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      recall_reg <= 1'b1;
    end else if (clk_en) begin
      recall_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= REG_RESET;
      end
    end else if (clk_en) begin
      if (recall_reg) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          regs_reg[i] <= nv_words[8*i +: 8];
        end
      end else if (nv_wr_valid) begin
        regs_reg[ptr_reg[2:0]] <= wbuf_reg;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_flat[8*i +: 8] = regs_reg[i];
    end
  end

  // Spare bits of register 2 and registers 3, 4 feed no output
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= '0;
    end else if (clk_en) begin
      cfg.ref_code           <= regs_reg[ADDR_REF_SCALE[2:0]];
      cfg.slope_code         <= regs_reg[ADDR_TEMP_SLOPE[2:0]];
      cfg.slope_factor       <= slope_decode(regs_reg[ADDR_TEMP_SLOPE[2:0]]);
      cfg.output_gain_factor <= gain_decode(
        regs_reg[ADDR_GAIN_SPARE[2:0]][GAIN_SEL_POS +: GAIN_SEL_W]);
    end
  end

  assign nv_wr = '{addr: ptr_reg, data: wbuf_reg};

  nvt_nv_store #(
    .WRITE_CYCLES (WRITE_CYCLES),
    .NUM          (NUM_REGS)
  ) u_store (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .wr_valid (nv_wr_valid),
    .wr       (nv_wr),
    .busy     (nv_busy),
    .words    (nv_words)
  );

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_id_nack;
    (scl_fall && st_reg == ST_ID && bit_cnt_reg == BIT_ACK && !id_match && !bus_hold
     && !start_det && !stop_det) |=> sda_oe_n;
  endproperty
  a_id_nack: assert property (p_id_nack) else $error("foreign ID acked");

  property p_early_stop;
    (stop_det && !wfull_reg) |-> !nv_wr_valid;
  endproperty
  a_early_stop: assert property (p_early_stop) else $error("write on early stop");

  property p_busy_after_commit;
    nv_wr_valid |=> nv_busy [*8];
  endproperty
  a_busy_after_commit: assert property (p_busy_after_commit) else $error("no write cycle");

  property p_busy_quiet;
    nv_busy |=> (sda_oe_n && st_reg == ST_IDLE);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("bus served while busy");

  property p_ptr_step;
    (ack_rise && st_reg == ST_RDATA && !stop_det && !start_det)
      |=> ptr_reg == $past(ptr_reg) + 8'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");

  property p_oor_data;
    (ack_rise && st_reg == ST_RDATA && !stop_det && !start_det && ptr_reg >= ADDR_LAST
     && ptr_reg != 8'hFF) |=> tx_reg == OUT_OF_RANGE_DATA;
  endproperty
  a_oor_data: assert property (p_oor_data) else $error("bad out of range data");

  property p_discard;
    (commit && ptr_reg > ADDR_LAST) |=> ($stable(regs_flat) && !nv_busy);
  endproperty
  a_discard: assert property (p_discard) else $error("out of range write stored");

  property p_store_a;
    (nv_wr_valid && ptr_reg == ADDR_SPARE_A) |=> regs_reg[3] == $past(wbuf_reg);
  endproperty
  a_store_a: assert property (p_store_a) else $error("storage byte not written");

  property p_spare_read;
    (ack_rise && st_reg == ST_ID && id_match && shift_reg[0] && !stop_det && !start_det
     && ptr_reg == ADDR_GAIN_SPARE) |=> tx_reg == $past(regs_reg[2]);
  endproperty
  a_spare_read: assert property (p_spare_read) else $error("register 2 readback wrong");

  property p_recall;
    $fell(recall_reg) |-> regs_flat == nv_words;
  endproperty
  a_recall: assert property (p_recall) else $error("recall mismatch");

  property p_gain4;
    (clk_en && regs_reg[2][1:0] == 2'h3) |=> cfg.output_gain_factor == 3'h4;
  endproperty
  a_gain4: assert property (p_gain4) else $error("gain 11 not x4");

  property p_slope_low;
    (clk_en && regs_reg[1] == 8'h00) |=> cfg.slope_factor == 9'h101;
  endproperty
  a_slope_low: assert property (p_slope_low) else $error("slope code 0 not -1");

  property p_ref;
    clk_en |=> cfg.ref_code == $past(regs_reg[0]);
  endproperty
  a_ref: assert property (p_ref) else $error("ref code mismatch");

  c_commit:     cover property (nv_wr_valid);
  c_read_byte:  cover property (ack_rise && st_reg == ST_RDATA);
  c_id_nack:    cover property (ack_rise && st_reg == ST_ID && !id_match);
  c_early_stop: cover property (stop_det && st_reg == ST_WDATA && !commit);

endmodule

`default_nettype wire

// ---- sim/nvt_i2c_master.sv ----
// Behavioural two-wire bus master driving the trim bank's bus pins
`timescale 1ns/100ps
`default_nettype none

module nvt_i2c_master #(
  parameter int HALF = 10
) (
  input  wire logic core_clk,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // ==========================================================================
  // Bus primitives, all changes at the falling core_clk edge
  task automatic wait_clk(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Also serves as repeated start: SDA rises only while SCL is low
  task automatic start();
    sda_drv = 1'b1;
    wait_clk(HALF);
    scl = 1'b1;
    wait_clk(HALF);
    sda_drv = 1'b0;
    wait_clk(HALF);
    scl = 1'b0;
    wait_clk(HALF);
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    wait_clk(HALF);
    scl = 1'b1;
    wait_clk(HALF);
    sda_drv = 1'b1;
    wait_clk(HALF);
  endtask

  // Gap after the SCL fall keeps SDA edges out of the high phase
  task automatic clock_bit(input logic b, output logic s);
    sda_drv = b;
    wait_clk(HALF);
    scl = 1'b1;
    wait_clk(HALF);
    s = sda_wire;
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
    clock_bit(~mack, s);
  endtask
endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the trim register bank
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import nvt_pkg::*;
  localparam int         WC    = 40;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [6:0] ID7   = {DEVICE_TYPE_DEF, STRAP};

  logic       core_clk;
  logic       reset_n;
  logic       scl;
  logic       m_sda;
  logic       sda_wire;
  logic       sda_out;
  logic       sda_oe_n;
  logic       nv_busy;
  nvt_cfg_t   cfg;
  int         miscompares;
  int         n_compared;
  logic [7:0] rd [8];
  logic [7:0] wv [5] = '{8'hA5, 8'hFF, 8'hB7, 8'h3C, 8'hC3};
  logic [2:0] gtab [4] = '{3'h1, 3'h2, 3'h2, 3'h4};
  logic       a;

  // Pull-up wire: low whenever the device enables its driver
  assign sda_wire = m_sda & (sda_oe_n | sda_out);

  nvt_trim_bank #(.WRITE_CYCLES(WC), .DEVICE_TYPE(DEVICE_TYPE_DEF)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1), .scl_in(scl),
    .sda_in(sda_wire), .addr_strap_2(STRAP[2]), .addr_strap_1(STRAP[1]),
    .addr_strap_0(STRAP[0]), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .cfg(cfg), .nv_busy(nv_busy));

  nvt_i2c_master #(.HALF(10)) m (
    .core_clk(core_clk), .scl(scl), .sda_drv(m_sda), .sda_wire(sda_wire));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Compare and bus tasks
  task automatic check_val(input string nm, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check_bit(input string nm, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] ad, input logic [7:0] d, input logic busy_exp);
    logic k0, k1, k2;
    m.start();
    m.send_byte({ID7, 1'b0}, k0);
    m.send_byte(ad, k1);
    m.send_byte(d, k2);
    m.stop();
    check_bit("write ack", 1'b1, k0 & k1 & k2);
    check_bit("nv_busy", busy_exp, nv_busy);
  endtask

  task automatic settle();
    m.wait_clk(WC + 10);
  endtask

  task automatic reg_read(input logic [7:0] ad, input int n);
    logic k0, k1, k2;
    m.start();
    m.send_byte({ID7, 1'b0}, k0);
    m.send_byte(ad, k1);
    m.start();
    m.send_byte({ID7, 1'b1}, k2);
    for (int i = 0; i < n; i++) m.recv_byte(i < n - 1, rd[i]);
    m.stop();
    check_bit("read ack", 1'b1, k0 & k1 & k2);
  endtask

  // Sequential read from 0; beyond the last register the fill value comes back
  task automatic check_all(input int n);
    for (int i = 0; i < n; i++)
      check_val("readback", 9'(i < NUM_REGS ? wv[i] : OUT_OF_RANGE_DATA), 9'(rd[i]));
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    miscompares = 0;
    n_compared = 0;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    m.wait_clk(10);
    check_val("ref_code", 9'(NV_BLANK), 9'(cfg.ref_code));
    check_val("slope_factor", 9'h101, cfg.slope_factor);
    check_val("gain", 9'h1, 9'(cfg.output_gain_factor));
    $display("test recall_blank done");

    for (int i = 0; i < 5; i++) begin
      reg_write(8'(i), wv[i], 1'b1);
      settle();
    end
    reg_read(ADDR_REF_SCALE, 6);
    check_all(6);
    check_val("ref_code", 9'h0A5, 9'(cfg.ref_code));
    check_val("slope_code", 9'h0FF, 9'(cfg.slope_code));
    check_val("slope_factor", 9'h0FF, cfg.slope_factor);
    check_val("gain", 9'h4, 9'(cfg.output_gain_factor));
    $display("test write_readback done");

    for (int s = 0; s < 4; s++) begin
      reg_write(ADDR_GAIN_SPARE, {6'h2A, 2'(s)}, 1'b1);
      settle();
      check_val("gain", 9'(gtab[s]), 9'(cfg.output_gain_factor));
      reg_read(ADDR_GAIN_SPARE, 1);
      check_val("gain_spare", 9'({6'h2A, 2'(s)}), 9'(rd[0]));
    end
    wv[2] = 8'hAB;
    $display("test gain_decode done");

    reg_write(8'h05, 8'h00, 1'b0);
    m.wait_clk(10);
    reg_read(ADDR_REF_SCALE, 5);
    check_all(5);
    $display("test out_of_range_write done");

    for (int nb = 0; nb <= 4; nb += 4) begin
      m.start();
      m.send_byte({ID7, 1'b0}, a);
      m.send_byte(ADDR_SPARE_A, a);
      for (int j = 0; j < nb; j++) m.clock_bit(1'b0, a);
      m.stop();
      check_bit("nv_busy", 1'b0, nv_busy);
    end
    reg_read(ADDR_SPARE_A, 1);
    check_val("spare_a", 9'(wv[3]), 9'(rd[0]));
    $display("test early_stop done");

    for (int k = 0; k < 2; k++) begin
      m.start();
      m.send_byte({ID7 ^ (k == 0 ? 7'h01 : 7'h40), 1'b0}, a);
      m.stop();
      check_bit("bad id ack", 1'b0, a);
    end
    $display("test bad_id done");

    reg_write(ADDR_SPARE_B, 8'h5A, 1'b1);
    m.start();
    m.send_byte({ID7, 1'b1}, a);
    m.stop();
    check_bit("busy ack", 1'b0, a);
    settle();
    wv[4] = 8'h5A;
    $display("test busy_ignore done");

    reset_n = 1'b0;
    repeat (8) @(negedge core_clk);
    check_bit("sda_oe_n", 1'b1, sda_oe_n);
    check_bit("nv_busy", 1'b0, nv_busy);
    reset_n = 1'b1;
    m.wait_clk(10);
    check_val("ref_code", 9'(wv[0]), 9'(cfg.ref_code));
    check_val("slope_code", 9'(wv[1]), 9'(cfg.slope_code));
    check_val("gain", 9'h4, 9'(cfg.output_gain_factor));
    reg_read(ADDR_REF_SCALE, 5);
    check_all(5);
    $display("test reset_recall done");
    conclude();
  end
endmodule

`default_nettype wire
